/* File: hdl/dam_top.sv */
// dual actuator motion control core with ahb-lite register slave
//
// Overview of operation
// R1 - while retract is held the actuators are driven inward.
// R2 - while extend is held the actuators are driven outward.
// R3 - holding learn for more than 2.0 s starts an automatic stroke calibration; the code starts it only when a feedback type is set.
// R4 - calibration retracts to the end, extends to the other end, then returns to its start.
// R5 - fault out is high while overcurrent or lost position feedback is present.
// R6 - an opened normally closed emergency contact stops everything unless bypassed.
// R7 - in servo mode the setpoint maps linearly onto the learned stroke as a target.
// R8 - in servo mode position reached is raised once the target is reached.
// R9 - mode 0 is plain command drive, mode 1 is setpoint positioning.
// R10 - count 0 runs two actuators, count 1 runs one.
// R11 - feedback type selects two hall, one hall, potentiometer or none.
// R12 - software must not pair servo mode with the no feedback setting.
// R13 - without feedback two actuators run in parallel with no synchronisation.
// R14 - extend and retract together count as no command.
// R15 - with feedback and two actuators the leading drive pauses to keep positions equal; the code pauses it only with two hall or potentiometer feedback.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module dam_top #(
   parameter int unsigned LEARN_CYC = dam_pkg::LEARN_CYC,
   parameter int unsigned STALL_CYC = dam_pkg::STALL_CYC,
   parameter int SP_W = 12
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // operator and switch inputs
   input wire logic RETRACT_CMD_IN_I,
   input wire logic EXTEND_CMD_IN_I,
   input wire logic LEARN_CMD_IN_I,
   input wire logic EMERGENCY_OFF_IN_I,
   input wire logic ESTOP_BYPASS_JUMPER_I,
   input wire logic [SP_W-1:0] SETPOINT_I,
   // position feedback and power stage status, per channel
   input wire logic [15:0] POS_A_I,
   input wire logic [15:0] POS_B_I,
   input wire logic [1:0] OVERCURRENT_I,
   input wire logic [1:0] FEEDBACK_LOST_I,
   // drive and status outputs
   output logic [1:0] MOTOR_EXTEND_O,
   output logic [1:0] MOTOR_RETRACT_O,
   output logic FAULT_O,
   output logic POS_OK_O,
   output logic IRQ_O
);
   localparam int IN_W = 5 + SP_W + 32 + 4;

   // two-flop synchronisers for every pin input
   logic [IN_W-1:0] pin_raw, sync1_q, sync2_q;
   assign pin_raw = {RETRACT_CMD_IN_I, EXTEND_CMD_IN_I, LEARN_CMD_IN_I, EMERGENCY_OFF_IN_I,
      ESTOP_BYPASS_JUMPER_I, SETPOINT_I, POS_A_I, POS_B_I, OVERCURRENT_I, FEEDBACK_LOST_I};
   always_ff @(posedge SYS_CLK_I)
   begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
   end

   wire ret_in = sync2_q[IN_W-1];
   wire ext_in = sync2_q[IN_W-2];
   wire learn_in = sync2_q[IN_W-3];
   wire eoff_closed = sync2_q[IN_W-4];
   wire bypass_fitted = sync2_q[IN_W-5];
   wire [SP_W-1:0] setpoint = sync2_q[IN_W-6 -: SP_W];
   wire [15:0] pos_a = sync2_q[35:20];
   wire [15:0] pos_b = sync2_q[19:4];
   wire [1:0] ovc = sync2_q[3:2];
   wire [1:0] fb_lost = sync2_q[1:0];

   // configuration and register state
   logic [3:0] ctrl_q;
   logic [3:0] mask_q, stat_q, stat_d;
   logic [15:0] lim_min_q, lim_max_q, start_pos_q, pos_prev_q;
   logic [31:0] hold_q, stall_q;
   dam_pkg::dam_state_t state_q, state_d;
   logic fault_q, pos_ok_q, estop_q, irq_q, learned_q;
   logic [1:0] ext_q, ret_q;

   wire servo_mode = ctrl_q[dam_pkg::CTRL_MODE_BIT]; // R9
   wire single_act = ctrl_q[dam_pkg::CTRL_COUNT_BIT]; // R10
   wire [1:0] fb_type = ctrl_q[dam_pkg::CTRL_FB_LSB +: 2]; // R11
   wire has_fb = (fb_type != dam_pkg::FB_NONE); // R11
   wire two_fb = (fb_type == dam_pkg::FB_HALL2) || (fb_type == dam_pkg::FB_POT); // R11

   // only channels in use and with a sensor can report lost feedback
   wire [1:0] ch_used = single_act ? 2'b01 : 2'b11; // R10
   wire [1:0] fb_watch = has_fb ? (two_fb ? ch_used : 2'b01) : 2'b00;
   wire fault_now = |(ovc & ch_used) || |(fb_lost & fb_watch); // R5
   wire estop_now = !bypass_fitted && !eoff_closed; // R6

   // servo target: setpoint scaled over the learned span
   wire [15:0] span = lim_max_q - lim_min_q;
   wire [15+SP_W:0] scaled = span * setpoint; // R7
   wire [15:0] target = lim_min_q + scaled[15+SP_W:SP_W]; // R7
   wire below = (pos_a + dam_pkg::POS_TOL) < target;
   wire above = pos_a > (target + dam_pkg::POS_TOL);
   wire at_target = !below && !above; // R8

   // learn trigger and end-of-travel detection by stall
   wire learn_fire = learn_in && (hold_q == LEARN_CYC - 1); // R3
   wire stalled = (stall_q == STALL_CYC - 1); // R4
   wire [15:0] back_diff = (pos_a > start_pos_q) ? pos_a - start_pos_q : start_pos_q - pos_a;
   wire back_done = back_diff <= dam_pkg::POS_TOL; // R4

   // learn sequencer next state; stop or fault aborts the run
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         dam_pkg::DAM_IDLE:
            if (learn_fire && has_fb && !estop_now && !fault_now)
               state_d = dam_pkg::DAM_LRN_RET; // R3
         dam_pkg::DAM_LRN_RET:
            if (stalled)
               state_d = dam_pkg::DAM_LRN_EXT; // R4
         dam_pkg::DAM_LRN_EXT:
            if (stalled)
               state_d = dam_pkg::DAM_LRN_BACK; // R4
         dam_pkg::DAM_LRN_BACK:
            if (back_done)
               state_d = dam_pkg::DAM_IDLE; // R4
         default:
            state_d = dam_pkg::DAM_IDLE;
      endcase
      if (estop_now || fault_now)
         state_d = dam_pkg::DAM_IDLE; // R6
   end

   // requested direction before synchronisation and safety gating
   logic want_ext, want_ret;
   always_comb
   begin
      want_ext = 1'b0;
      want_ret = 1'b0;
      case (state_q)
         dam_pkg::DAM_LRN_RET:
            want_ret = 1'b1; // R4
         dam_pkg::DAM_LRN_EXT:
            want_ext = 1'b1; // R4
         dam_pkg::DAM_LRN_BACK:
         begin
            want_ext = pos_a < start_pos_q; // R4
            want_ret = pos_a > start_pos_q; // R4
         end
         default:
            if (servo_mode)
            begin
               want_ext = below; // R7
               want_ret = above; // R7
            end
            else
            begin
               want_ext = ext_in && !ret_in; // R2 R14
               want_ret = ret_in && !ext_in; // R1 R14
            end
      endcase
   end

   // leading drive waits while the other catches up; no sync with one hall or without feedback
   wire sync_on = two_fb && !single_act && state_q == dam_pkg::DAM_IDLE; // R13 R15
   wire a_ahead_ext = sync_on && want_ext && pos_a > pos_b + dam_pkg::SYNC_TOL; // R15
   wire b_ahead_ext = sync_on && want_ext && pos_b > pos_a + dam_pkg::SYNC_TOL; // R15
   wire a_ahead_ret = sync_on && want_ret && pos_b > pos_a + dam_pkg::SYNC_TOL; // R15
   wire b_ahead_ret = sync_on && want_ret && pos_a > pos_b + dam_pkg::SYNC_TOL; // R15
   wire drive_ok = !estop_now && !fault_now; // R6
   wire [1:0] ext_d = {want_ext && !b_ahead_ext, want_ext && !a_ahead_ext} & ch_used
      & {2{drive_ok}}; // R2 R10 R13
   wire [1:0] ret_d = {want_ret && !b_ahead_ret, want_ret && !a_ahead_ret} & ch_used
      & {2{drive_ok}}; // R1 R10 R13
   wire pos_ok_d = servo_mode && has_fb && state_q == dam_pkg::DAM_IDLE && at_target; // R8

   // ahb-lite address phase decode
   logic [7:0] addr_q;
   logic wr_q;
   wire ahb_take = HSEL_I && HTRANS_I[1] && HREADY_I;
   wire wr_ctrl = wr_q && addr_q == dam_pkg::CTRL_OFS;
   wire wr_stat = wr_q && addr_q == dam_pkg::IRQ_STAT_OFS;
   wire wr_mask = wr_q && addr_q == dam_pkg::IRQ_MASK_OFS;
   wire [7:0] rd_addr = HADDR_I[7:0];
   wire [31:0] status_word = {26'h0000000, learned_q, state_q, estop_q, pos_ok_q, fault_q};
   wire [31:0] rd_mux =
      (rd_addr == dam_pkg::CTRL_OFS) ? {28'h0000000, ctrl_q} :
      (rd_addr == dam_pkg::STATUS_OFS) ? status_word :
      (rd_addr == dam_pkg::IRQ_STAT_OFS) ? {28'h0000000, stat_q} :
      (rd_addr == dam_pkg::IRQ_MASK_OFS) ? {28'h0000000, mask_q} :
      (rd_addr == dam_pkg::LIMITS_OFS) ? {lim_max_q, lim_min_q} : 32'h00000000;

   // sticky events: a new event wins over a write-one clear in the same cycle
   wire [3:0] events;
   assign events[dam_pkg::EV_FAULT] = fault_now && !fault_q;
   assign events[dam_pkg::EV_POS_OK] = pos_ok_d && !pos_ok_q;
   assign events[dam_pkg::EV_LEARN_DONE] = state_q == dam_pkg::DAM_LRN_BACK
      && state_d == dam_pkg::DAM_IDLE;
   assign events[dam_pkg::EV_ESTOP] = estop_now && !estop_q;
   assign stat_d = (stat_q & ~(wr_stat ? HWDATA_I[3:0] : 4'h0)) | events;

   // bus slave registers; zero wait states, always okay
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         HRDATA_O <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
         ctrl_q <= dam_pkg::CTRL_RST;
         mask_q <= dam_pkg::IRQ_MASK_RST;
         stat_q <= 4'h0;
         IRQ_O <= 1'b0;
      end
      else
      begin
         addr_q <= rd_addr;
         wr_q <= ahb_take && HWRITE_I;
         if (ahb_take && !HWRITE_I)
            HRDATA_O <= rd_mux;
         if (wr_ctrl)
            ctrl_q <= HWDATA_I[3:0]; // R9 R10 R11
         if (wr_mask)
            mask_q <= HWDATA_I[3:0];
         stat_q <= stat_d;
         IRQ_O <= |(stat_q & mask_q);
      end
   end

   // learn hold timer, stall timer and learned limits
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         hold_q <= 32'h00000000;
         stall_q <= 32'h00000000;
         pos_prev_q <= 16'h0000;
         start_pos_q <= 16'h0000;
         lim_min_q <= 16'h0000;
         lim_max_q <= 16'hffff;
         learned_q <= 1'b0;
         state_q <= dam_pkg::DAM_IDLE;
      end
      else
      begin
         // saturates so one long press starts only one run
         if (!learn_in)
            hold_q <= 32'h00000000; // R3
         else if (hold_q != LEARN_CYC)
            hold_q <= hold_q + 32'h00000001; // R3
         pos_prev_q <= pos_a;
         if (pos_a != pos_prev_q || state_d != state_q)
            stall_q <= 32'h00000000;
         else if (!stalled)
            stall_q <= stall_q + 32'h00000001;
         if (state_q == dam_pkg::DAM_IDLE && state_d == dam_pkg::DAM_LRN_RET)
            start_pos_q <= pos_a; // R4
         if (state_q == dam_pkg::DAM_LRN_RET && stalled)
            lim_min_q <= pos_a; // R4
         if (state_q == dam_pkg::DAM_LRN_EXT && stalled)
            lim_max_q <= pos_a; // R4
         if (events[dam_pkg::EV_LEARN_DONE])
            learned_q <= 1'b1;
         state_q <= state_d;
      end
   end

   // registered drive and status pins
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         ext_q <= 2'b00;
         ret_q <= 2'b00;
         fault_q <= 1'b0;
         pos_ok_q <= 1'b0;
         estop_q <= 1'b0;
      end
      else
      begin
         ext_q <= ext_d; // R2
         ret_q <= ret_d; // R1
         fault_q <= fault_now; // R5
         pos_ok_q <= pos_ok_d; // R8
         estop_q <= estop_now; // R6
      end
   end

   assign MOTOR_EXTEND_O = ext_q;
   assign MOTOR_RETRACT_O = ret_q;
   assign FAULT_O = fault_q;
   assign POS_OK_O = pos_ok_q;
endmodule
`default_nettype wire

/* File: hdl/dam_pkg.sv */
// constants, offsets and types for the dual actuator motion controller
`default_nettype none
package dam_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   localparam logic [7:0] LIMITS_OFS = 8'h10;
   // control field positions
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_COUNT_BIT = 1;
   localparam int CTRL_FB_LSB = 2;
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // interrupt event bit positions
   localparam int EV_FAULT = 0;
   localparam int EV_POS_OK = 1;
   localparam int EV_LEARN_DONE = 2;
   localparam int EV_ESTOP = 3;
   // feedback type codes
   localparam logic [1:0] FB_HALL2 = 2'b00;
   localparam logic [1:0] FB_HALL1 = 2'b01;
   localparam logic [1:0] FB_POT = 2'b10;
   localparam logic [1:0] FB_NONE = 2'b11;
   // timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned LEARN_HOLD_MS = 2000;
   localparam int unsigned STALL_MS = 100;
   localparam int unsigned LEARN_CYC = LEARN_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned STALL_CYC = STALL_MS * (CLK_HZ / 1000);
   // position tolerances in feedback counts
   localparam logic [15:0] POS_TOL = 16'h0004;
   localparam logic [15:0] SYNC_TOL = 16'h0008;
   // learn sequencer states
   typedef enum logic [1:0] {
      DAM_IDLE = 2'b00,
      DAM_LRN_RET = 2'b01,
      DAM_LRN_EXT = 2'b10,
      DAM_LRN_BACK = 2'b11
   } dam_state_t;
endpackage
`default_nettype wire

/* File: tb/dam_chk.sv */
// assertion checker for the motion control core, bound to its top
`default_nettype none
module dam_chk (
   // clock, reset and bus
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   // operator pins and outputs
   input wire logic RETRACT_CMD_IN_I,
   input wire logic EXTEND_CMD_IN_I,
   input wire logic LEARN_CMD_IN_I,
   input wire logic EMERGENCY_OFF_IN_I,
   input wire logic ESTOP_BYPASS_JUMPER_I,
   input wire logic [1:0] OVERCURRENT_I,
   input wire logic [1:0] MOTOR_EXTEND_O,
   input wire logic [1:0] MOTOR_RETRACT_O,
   input wire logic FAULT_O,
   input wire logic POS_OK_O
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);
   logic wr_q;
   logic lrn_q;
   logic [3:0] ctl_q;
   logic [1:0] age_q;
   // mode shadow; checks hold off three cycles after a mode write
   wire logic wr_d = HSEL_I && HTRANS_I[1] && HREADYOUT_O && HWRITE_I && HADDR_I[7:0] == 8'h00;
   wire logic calm = age_q == 2'd3 && !lrn_q;
   wire logic run = calm && !ctl_q[0] && ctl_q[3:2] == 2'b11;
   wire logic [1:0] both = ctl_q[1] ? 2'b01 : 2'b11;
   wire logic ok = (EMERGENCY_OFF_IN_I || ESTOP_BYPASS_JUMPER_I) && OVERCURRENT_I == 2'b00;
   wire logic ret1 = ok && RETRACT_CMD_IN_I && !EXTEND_CMD_IN_I;
   wire logic ext1 = ok && EXTEND_CMD_IN_I && !RETRACT_CMD_IN_I;
   wire logic two = RETRACT_CMD_IN_I && EXTEND_CMD_IN_I;
   wire logic halt = !EMERGENCY_OFF_IN_I && !ESTOP_BYPASS_JUMPER_I;
   wire logic no_oc = OVERCURRENT_I == 2'b00;
   wire logic [3:0] mot = {MOTOR_EXTEND_O, MOTOR_RETRACT_O};
   // learning is not modelled here, so the command drive checks stop once it may start; the stop check stays on
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         wr_q <= 1'b0;
         lrn_q <= 1'b0;
         ctl_q <= 4'h0;
         age_q <= 2'd3;
      end
      else
      begin
         wr_q <= wr_d;
         lrn_q <= lrn_q || LEARN_CMD_IN_I;
         ctl_q <= wr_q ? HWDATA_I[3:0] : ctl_q;
         age_q <= wr_q ? 2'd0 : (age_q == 2'd3 ? age_q : age_q + 2'd1);
      end
   end
   ret_drive_a: assert property (run && $past(ret1, 3) |-> mot == {2'b00, both})
      else $error("retract drive wrong");
   ext_drive_a: assert property (run && $past(ext1, 3) |-> mot == {both, 2'b00})
      else $error("extend drive wrong");
   cmd_none_a: assert property (run && $past(two, 3) |-> mot == 4'h0)
      else $error("drive with both commands");
   estop_stop_a: assert property ($past(halt, 3) |-> mot == 4'h0)
      else $error("drive during stop");
   fault_out_a: assert property ($past(OVERCURRENT_I[0], 3) |-> FAULT_O)
      else $error("fault missing");
   fault_src_a: assert property (calm && ctl_q[3:2] == 2'b11 && $past(no_oc, 3) |-> !FAULT_O)
      else $error("fault without cause");
   posok_mode_a: assert property (calm && !ctl_q[0] |-> !POS_OK_O)
      else $error("position ok in plain mode");
   bus_okay_a: assert property (HSEL_I && HTRANS_I[1] |=> HREADYOUT_O && !HRESP_O)
      else $error("bus answer not okay");
endmodule
bind dam_top dam_chk i_chk (
   .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
   .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .RETRACT_CMD_IN_I(RETRACT_CMD_IN_I),
   .EXTEND_CMD_IN_I(EXTEND_CMD_IN_I), .LEARN_CMD_IN_I(LEARN_CMD_IN_I),
   .EMERGENCY_OFF_IN_I(EMERGENCY_OFF_IN_I), .ESTOP_BYPASS_JUMPER_I(ESTOP_BYPASS_JUMPER_I),
   .OVERCURRENT_I(OVERCURRENT_I), .MOTOR_EXTEND_O(MOTOR_EXTEND_O),
   .MOTOR_RETRACT_O(MOTOR_RETRACT_O), .FAULT_O(FAULT_O), .POS_OK_O(POS_OK_O));
`default_nettype wire

/* File: tb/dam_act.sv */
// actuator pair and stop contact at the controller's far side
`default_nettype none
module dam_act #(
   parameter logic [15:0] LO = 16'h0100,
   parameter logic [15:0] HI = 16'h0140
) (
   // drive and stop request in
   input wire logic clk_i,
   input wire logic [1:0] ext_i,
   input wire logic [1:0] ret_i,
   input wire logic stop_i,
   // contact and feedback out
   output logic estop_n_o,
   output logic [15:0] pos_a_o,
   output logic [15:0] pos_b_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] pos_q [2] = '{16'h0120, 16'h0120};
   // normally closed: pressing stop opens the loop
   assign estop_n_o = !stop_i;
   assign pos_a_o = pos_q[0];
   assign pos_b_o = pos_q[1];
   // one count per driven cycle; hard ends stall the rod
   always @(posedge clk_i)
      for (int i = 0; i < 2; i++)
         if (ext_i[i] && !ret_i[i] && pos_q[i] < HI)
            pos_q[i] <= pos_q[i] + 16'h0001;
         else if (ret_i[i] && !ext_i[i] && pos_q[i] > LO)
            pos_q[i] <= pos_q[i] - 16'h0001;
endmodule
`default_nettype wire

/* File: tb/tb_dam_top.sv */
// self-checking bench for the motion control core
`default_nettype none
module tb_dam_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [8:0] pin = 9'h000;
   logic [11:0] sp = 12'h000;
   logic [31:0] hrdata;
   logic [31:0] r;
   logic hready;
   logic fault;
   logic pok;
   logic irq;
   logic estop_n;
   logic [1:0] mext;
   logic [1:0] mret;
   logic [15:0] pa;
   logic [15:0] pb;
   logic [15:0] st;
   int miscompares = 0;
   int total_checks = 0;
   int seed = 76;
   int cyc = 0;
   int n;
   // pin: fb lost, learn, overcurrent, jumper, stop, extend, retract
   dam_top #(.LEARN_CYC(LC), .STALL_CYC(8), .SP_W(12)) i_dut (
      .SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .RETRACT_CMD_IN_I(pin[0]),
      .EXTEND_CMD_IN_I(pin[1]), .EMERGENCY_OFF_IN_I(estop_n), .ESTOP_BYPASS_JUMPER_I(pin[3]),
      .OVERCURRENT_I(pin[5:4]), .LEARN_CMD_IN_I(pin[6]), .FEEDBACK_LOST_I(pin[8:7]),
      .SETPOINT_I(sp), .POS_A_I(pa), .POS_B_I(pb), .MOTOR_EXTEND_O(mext),
      .MOTOR_RETRACT_O(mret), .FAULT_O(fault), .POS_OK_O(pok), .IRQ_O(irq));
   dam_act i_act (.clk_i(clk), .ext_i(mext), .ret_i(mret), .stop_i(pin[2]),
      .estop_n_o(estop_n), .pos_a_o(pa), .pos_b_o(pb));
   always #12.5 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         miscompares++;
         finish_test;
      end
   end
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
      chk_reg({28'h0, g}, {28'h0, e});
   endtask
   // one single word transfer; waits on ready in both phases
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk_reg(r, e);
   endtask
   // pins pass two sync flops and an output flop
   task automatic put(input logic [8:0] v);
      @(posedge clk);
      pin <= v;
      repeat (4) @(posedge clk);
   endtask
   task automatic await(input logic p);
      for (int i = 0; i < 2000 && (p ? pok : irq) !== 1'b1; i++)
         @(posedge clk);
   endtask
   function automatic logic [3:0] drv(input logic e, input logic t, input logic c);
      logic [1:0] m;
      m = c ? 2'b01 : 2'b11;
      return {e && !t ? m : 2'b00, t && !e ? m : 2'b00};
   endfunction
   function automatic logic near(input logic [15:0] a, input logic [15:0] b);
      return (a > b ? a - b : b - a) <= 16'h0004;
   endfunction
   function automatic logic [15:0] tgt(input logic [11:0] s);
      logic [31:0] p;
      p = {20'h0, s} * 32'h40;
      return 16'h0100 + p[27:12];
   endfunction
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(dam_pkg::CTRL_OFS, 32'h0);
      rd(dam_pkg::IRQ_MASK_OFS, 32'h0);
      rd(dam_pkg::LIMITS_OFS, 32'hffff0000);
      rd(8'h14, 32'h0);
      repeat (3)
      begin
         n = $random(seed);
         n[3] = n[3] & ~n[0];
         ahb(1'b1, dam_pkg::CTRL_OFS, n);
         rd(dam_pkg::CTRL_OFS, {28'h0, n[3:0]});
      end
      $display("registers done");
      for (int c = 0; c < 2; c++)
      begin
         ahb(1'b1, dam_pkg::CTRL_OFS, {28'h0, 2'b11, c[0], 1'b0});
         for (int k = 0; k < 4; k++)
         begin
            put({7'h0, k[1:0]});
            chk_pin({mext, mret}, drv(k[1], k[0], c[0]));
         end
      end
      put(9'h005);
      chk_pin({mext, mret}, 4'h0);
      put(9'h00d);
      chk_pin({mext, mret}, 4'h1);
      $display("commands done");
      put(9'h011);
      chk_pin({3'h0, fault}, 4'h1);
      put(9'h100);
      for (int f = 0; f < 4; f++)
      begin
         ahb(1'b1, dam_pkg::CTRL_OFS, {28'h0, f[1:0], 2'b00});
         repeat (4) @(posedge clk);
         chk_pin({3'h0, fault}, {3'h0, f == 0 || f == 2});
      end
      put(9'h000);
      ahb(1'b1, dam_pkg::IRQ_MASK_OFS, 32'h1);
      repeat (2) @(posedge clk);
      chk_pin({3'h0, irq}, 4'h1);
      ahb(1'b1, dam_pkg::IRQ_STAT_OFS, 32'h1);
      repeat (2) @(posedge clk);
      chk_pin({3'h0, irq}, 4'h0);
      $display("faults done");
      ahb(1'b1, dam_pkg::CTRL_OFS, 32'ha);
      ahb(1'b1, dam_pkg::IRQ_MASK_OFS, 32'h4);
      put(9'h040);
      put(9'h000);
      rd(dam_pkg::STATUS_OFS, 32'h0);
      st = pa;
      put(9'h040);
      repeat (LC + 4) @(posedge clk);
      put(9'h000);
      await(1'b0);
      rd(dam_pkg::LIMITS_OFS, 32'h01400100);
      chk_pin({3'h0, near(pa, st)}, 4'h1);
      rd(dam_pkg::STATUS_OFS, 32'h20);
      $display("learn done");
      ahb(1'b1, dam_pkg::CTRL_OFS, 32'hb);
      repeat (3)
      begin
         n = $random(seed);
         sp <= n[11:0];
         repeat (8) @(posedge clk);
         await(1'b1);
         chk_pin({3'h0, near(pa, tgt(sp))}, 4'h1);
      end
      $display("servo done");
      // park both rods at the inner end, then give channel 0 a lead of about 21 counts
      ahb(1'b1, dam_pkg::CTRL_OFS, 32'hc);
      put(9'h001);
      repeat (LC * 4) @(posedge clk);
      ahb(1'b1, dam_pkg::CTRL_OFS, 32'he);
      put(9'h002);
      repeat (16) @(posedge clk);
      // without regulation the lead would stay at 21; with it channel 1 must catch up
      ahb(1'b1, dam_pkg::CTRL_OFS, 32'h8);
      put(9'h002);
      repeat (LC) @(posedge clk);
      chk_pin({3'h0, (pa > pb ? pa - pb : pb - pa) <= 16'h000c && pb > 16'h0104}, 4'h1);
      put(9'h000);
      $display("sync done");
      finish_test;
   end
endmodule
`default_nettype wire
